/* design/bmst_core.v */
// Contract
// RL1: On-chip memory costs one state per cycle
// RL2: Total equals sum of class count times cost
// RL3: Fetch, branch, stack costs depend on region
// RL4: Byte and word data costs on 8-bit bus
// RL5: Extend register adds one state when enabled
// RL6: Word-count move copies until count zero
// RL7: Byte-count move uses low count byte
// RL8: Block move takes four plus two per byte
// RL9: m is configured external wait states
// RL10: On-chip memory: one state, 16-bit path
// RL11: Move interruptible only between iterations
`include "bmst_defines.vh"
module bmst_core #(
    parameter WAIT_W = 4                // Width of wait-state count
) (
    input  wire              clk_i,
    input  wire              nrst_i,
    // State-count calculator
    input  wire [2:0]        code_region_i,  // Where opcode lives
    input  wire [2:0]        data_region_i,  // Where operands live
    input  wire [WAIT_W-1:0] wait_m_i,       // External wait states
    input  wire              ext_en_i,       // Extend register enabled
    input  wire              ext_aff_i,      // Insn affected by it
    input  wire [7:0]        cnt_fetch_i,    // Fetch cycles
    input  wire [7:0]        cnt_branch_i,   // Branch-address reads
    input  wire [7:0]        cnt_stack_i,    // Stack operations
    input  wire [7:0]        cnt_byte_i,     // Byte data cycles
    input  wire [7:0]        cnt_word_i,     // Word data cycles
    input  wire [7:0]        cnt_int_i,      // Internal operations
    output reg  [19:0]       exec_states_o,  // Registered result
    // Block move
    input  wire              move_start_i,   // Start pulse
    input  wire              move_word_i,    // 1: word count variant
    input  wire              intr_req_i,     // Interrupt request level
    input  wire [15:0]       count_ld_i,     // Initial count
    input  wire [31:0]       src_ld_i,       // Initial source pointer
    input  wire [31:0]       dst_ld_i,       // Initial dest pointer
    output wire              move_busy_o,    // Move in progress
    output reg               move_done_o,    // Finished, one cycle
    output reg               move_susp_o,    // Left at boundary, one cycle
    output reg  [15:0]       word_count_reg, // Count register
    output reg  [31:0]       source_pointer_reg,
    output reg  [31:0]       dest_pointer_reg,
    output reg  [19:0]       move_states_o,  // Cost of last move
    // Memory port, one-state on-chip access
    output reg               mem_rd_o,       // Read strobe
    output reg               mem_wr_o,       // Write strobe
    output reg  [31:0]       mem_addr_o,     // Address
    input  wire [7:0]        mem_rdata_i,    // Read data, same cycle as strobe
    output reg  [7:0]        mem_wdata_o     // Write data
);
    // Byte count is the low half of the count register
    // Byte variant loads the high half at start but never counts it down
    wire [7:0] byte_count_reg = word_count_reg[7:0];

    // Cost of one fetch-class cycle for a region
    // RL3: region fetch cost
    function [7:0] fcost;
        input [2:0]        r;
        input [WAIT_W-1:0] m;
        begin
            case (r)
                `BMST_REG_PER8:    fcost = `BMST_ST_FOUR;
                `BMST_REG_PER16:   fcost = `BMST_ST_TWO;
                `BMST_REG_EXT8_2:  fcost = `BMST_ST_FOUR;
                // RL9: m wait states
                `BMST_REG_EXT8_3:  fcost = `BMST_ST_SIX + {3'h0, m, 1'b0};
                `BMST_REG_EXT16_2: fcost = `BMST_ST_TWO;
                `BMST_REG_EXT16_3: fcost = `BMST_ST_THREE + {4'h0, m};
                // RL1: one state on-chip
                default:           fcost = `BMST_ST_ONE;
            endcase
        end
    endfunction

    // Byte and word data costs; 16-bit regions use fetch cost
    // RL4: 8-bit bus data
    function [7:0] bcost;
        input [2:0]        r;
        input [WAIT_W-1:0] m;
        begin
            case (r)
                `BMST_REG_PER8:   bcost = `BMST_ST_TWO;
                `BMST_REG_EXT8_2: bcost = `BMST_ST_TWO;
                `BMST_REG_EXT8_3: bcost = `BMST_ST_THREE + {4'h0, m};
                default:          bcost = fcost(r, m);
            endcase
        end
    endfunction

    // RL10: on-chip word in one state
    function [7:0] wcost;
        input [2:0]        r;
        input [WAIT_W-1:0] m;
        begin
            case (r)
                `BMST_REG_PER8:   wcost = `BMST_ST_FOUR;
                `BMST_REG_EXT8_2: wcost = `BMST_ST_FOUR;
                `BMST_REG_EXT8_3: wcost = `BMST_ST_SIX + {3'h0, m, 1'b0};
                default:          wcost = fcost(r, m);
            endcase
        end
    endfunction

    // Per-class costs for the current regions
    wire [7:0] fc_code = fcost(code_region_i, wait_m_i); // Opcode fetch
    wire [7:0] fc_data = fcost(data_region_i, wait_m_i); // Branch, stack
    wire [7:0] bc_data = bcost(data_region_i, wait_m_i); // Byte data
    wire [7:0] wc_data = wcost(data_region_i, wait_m_i); // Word data

    // Weighted sum of the six cycle classes
    // Products widened to 16 bits first: an 8 by 8 product taken
    // self-determined inside a concatenation would wrap at 256
    reg [19:0] next_exec;
    always @* begin
        // RL2: sum of products
        next_exec = {4'h0, {8'h00, cnt_fetch_i} * {8'h00, fc_code}}
            + {4'h0, {8'h00, cnt_branch_i} * {8'h00, fc_data}}
            + {4'h0, {8'h00, cnt_stack_i} * {8'h00, fc_data}}
            + {4'h0, {8'h00, cnt_byte_i} * {8'h00, bc_data}}
            + {4'h0, {8'h00, cnt_word_i} * {8'h00, wc_data}}
            + {12'h000, cnt_int_i};
        // RL5: extend register penalty
        if (ext_en_i && ext_aff_i)
            next_exec = next_exec + 20'h00001;
    end

    // Result register
    // Zero until the first sum is taken
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            exec_states_o <= 20'h00000;
        else
            exec_states_o <= next_exec;
    end

    // Move sequencer states
    // Two states per byte line up with the per-byte cost
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_READ = 2'h1;  // Issue source read
    localparam [1:0] S_WRITE = 2'h2; // Write fetched byte
    reg  [1:0] state;
    reg        word_mode;            // Variant latched at start
    assign move_busy_o = (state != S_IDLE);

    // Count left for the running variant
    wire count_zero = word_mode ? (word_count_reg == 16'h0000)
                                : (byte_count_reg == 8'h00);

    // Block move loop, one byte every two states
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state              <= S_IDLE;
            word_mode          <= 1'b0;
            word_count_reg     <= 16'h0000;
            source_pointer_reg <= 32'h00000000;
            dest_pointer_reg   <= 32'h00000000;
            move_states_o      <= 20'h00000;
            move_done_o        <= 1'b0;
            move_susp_o        <= 1'b0;
            mem_rd_o           <= 1'b0;
            mem_wr_o           <= 1'b0;
            mem_addr_o         <= 32'h00000000;
            mem_wdata_o        <= 8'h00;
        end else begin
            move_done_o <= 1'b0;
            move_susp_o <= 1'b0;
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            case (state)
                S_IDLE: begin
                    // Start is ignored unless idle
                    if (move_start_i) begin
                        word_mode          <= move_word_i;
                        word_count_reg     <= count_ld_i;
                        source_pointer_reg <= src_ld_i;
                        dest_pointer_reg   <= dst_ld_i;
                        // RL8: four plus two per byte
                        // Documented cost, not the loop's own cycles
                        move_states_o <= `BMST_MOVE_BASE + `BMST_MOVE_PER
                            * (move_word_i ? {4'h0, count_ld_i}
                                           : {12'h000, count_ld_i[7:0]});
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    // RL11: stop only between bytes
                    if (count_zero) begin
                        // Nothing left: report and go idle
                        move_done_o <= 1'b1;
                        state       <= S_IDLE;
                    end else if (intr_req_i) begin
                        // Registers are consistent for a resume
                        move_susp_o <= 1'b1;
                        state       <= S_IDLE;
                    end else begin
                        // Fetch the next source byte
                        mem_rd_o   <= 1'b1;
                        mem_addr_o <= source_pointer_reg;
                        state      <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    // RL6: copy, bump pointers, count down
                    // Read data is taken in the strobe's own state
                    mem_wr_o           <= 1'b1;
                    mem_addr_o         <= dest_pointer_reg;
                    mem_wdata_o        <= mem_rdata_i;
                    source_pointer_reg <= source_pointer_reg + 32'h1;
                    dest_pointer_reg   <= dest_pointer_reg + 32'h1;
                    // RL7: byte variant keeps high half
                    if (word_mode)
                        word_count_reg <= word_count_reg - 16'h0001;
                    else
                        word_count_reg[7:0] <= byte_count_reg - 8'h01;
                    state <= S_READ;
                end
                // Unused code: recover to idle
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // bmst_core

/* inc/bmst_defines.vh */
`ifndef BMST_DEFINES_VH
`define BMST_DEFINES_VH
// Access region codes
`define BMST_REG_ONCHIP  3'h0
`define BMST_REG_PER8    3'h1
`define BMST_REG_PER16   3'h2
`define BMST_REG_EXT8_2  3'h3
`define BMST_REG_EXT8_3  3'h4
`define BMST_REG_EXT16_2 3'h5
`define BMST_REG_EXT16_3 3'h6
// Per-cycle state costs
`define BMST_ST_ONE      8'h01
`define BMST_ST_TWO      8'h02
`define BMST_ST_THREE    8'h03
`define BMST_ST_FOUR     8'h04
`define BMST_ST_SIX      8'h06
// Block move fixed overhead and per-byte cost
`define BMST_MOVE_BASE   20'h00004
`define BMST_MOVE_PER    20'h00002
`endif

/* test/block_move_and_state_timing_tb.sv */
module block_move_and_state_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, nrst_i, ext_en_i, ext_aff_i, move_start_i, move_word_i;
    logic intr_req_i, move_busy_o, move_done_o, move_susp_o, rd, wr;
    logic [2:0] code_region_i, data_region_i;
    logic [3:0] wait_m_i;
    logic [7:0] cf, cb, ck, cl, cm, cn, rdat, wdat;
    logic [15:0] count_ld_i, word_count_reg;
    logic [19:0] exec_states_o, move_states_o;
    logic [31:0] src_ld_i, dst_ld_i, source_pointer_reg, dest_pointer_reg, adr;
    logic [19:0] cq[$];  // Expected state sums
    logic [99:0] mq[$];  // Expected move outcome
    int n_errors = 0, num_checks = 0, seed = 95615;
    initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
    bmst_core i_dut (.clk_i, .nrst_i, .code_region_i, .data_region_i,
        .wait_m_i, .ext_en_i, .ext_aff_i, .cnt_fetch_i(cf), .cnt_branch_i(cb),
        .cnt_stack_i(ck), .cnt_byte_i(cl), .cnt_word_i(cm), .cnt_int_i(cn),
        .exec_states_o, .move_start_i, .move_word_i, .intr_req_i, .count_ld_i,
        .src_ld_i, .dst_ld_i, .move_busy_o, .move_done_o, .move_susp_o,
        .word_count_reg, .source_pointer_reg, .dest_pointer_reg,
        .move_states_o, .mem_rd_o(rd), .mem_wr_o(wr), .mem_addr_o(adr),
        .mem_rdata_i(rdat), .mem_wdata_o(wdat));
    bmst_mem_model i_mem (.clk_i, .rd_i(rd), .wr_i(wr), .addr_i(adr),
        .wdata_i(wdat), .rdata_o(rdat));
    task automatic note(input logic ok);
        num_checks++;
        if (!ok) begin n_errors++; $display("Error at %0t: mismatch", $time); end
    endtask
    task automatic chk_st(input logic [19:0] g, e); note(g === e); endtask
    task automatic chk_mv(input logic [99:0] g, e); note(g === e); endtask
    task automatic chk_byte(input logic [7:0] g, e); note(g === e); endtask
    // Cost of one cycle: k 0 fetch class, 1 byte, 2 word
    function automatic logic [19:0] cost(input logic [2:0] r, input int k);
        case (r)
            3'h0: cost = 1;
            3'h1, 3'h3: cost = (k == 1) ? 2 : 4;
            3'h2, 3'h5: cost = 2;
            3'h4: cost = (k == 1) ? 3 + wait_m_i : 6 + 2 * wait_m_i;
            default: cost = 3 + wait_m_i;
        endcase
    endfunction
    // Random calculator case over every region code
    task automatic calc();
        @(posedge clk_i); #1;
        {cf, cb, ck, cl, cm, cn} = 48'({$random(seed), $random(seed)});
        {wait_m_i, ext_en_i, ext_aff_i} = 6'($random(seed));
        code_region_i = 3'({$random(seed)} % 7);
        data_region_i = 3'({$random(seed)} % 7);
        cq.push_back(cf * cost(code_region_i, 0) + cn + (ext_en_i & ext_aff_i)
            + (cb + ck) * cost(data_region_i, 0) + cl * cost(data_region_i, 1)
            + cm * cost(data_region_i, 2));
    endtask
    // One move; k > 0 raises the interrupt k cycles in
    task automatic move(input logic w, input logic [15:0] c,
                        input logic [31:0] s, d, input int k);
        logic [15:0] n;
        n = w ? c : {8'h00, c[7:0]};
        @(posedge clk_i); #1;
        {move_word_i, count_ld_i, src_ld_i, dst_ld_i} = {w, c, s, d};
        move_start_i = 1;
        mq.push_back({20'(4 + 2 * n), w ? 16'h0 : {c[15:8], 8'h00}, s + n, d + n});
        @(posedge clk_i); #1;
        move_start_i = 0;
        if (k > 0) begin
            repeat (k) @(posedge clk_i);
            #1 intr_req_i = 1;
        end
        for (int i = 0; i < 400 && !move_done_o && !move_susp_o; i++) begin
            @(posedge clk_i); #1;
        end
        // A move that never ends counts as a mismatch
        if (move_done_o !== 1'b1 && move_susp_o !== 1'b1) note(1'b0);
        intr_req_i = 0;
        for (int i = 0; i < n && k == 0; i++)
            chk_byte(i_mem.mem[8'(d + i)], 8'(s + i) ^ 8'h5a);
    endtask
    // Oldest expectation meets each result
    always @(posedge clk_i) begin
        int due;
        logic [99:0] e;
        due = cq.size();
        #2;
        if (due > 0) chk_st(exec_states_o, cq.pop_front());
        if (move_done_o === 1'b1) chk_mv({move_states_o, word_count_reg,
            source_pointer_reg, dest_pointer_reg}, mq.pop_front());
        if (move_susp_o === 1'b1) begin
            e = mq.pop_front();
            chk_mv({source_pointer_reg + word_count_reg,
                dest_pointer_reg + word_count_reg}, e[63:0]);
        end
    end
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin #200000; n_errors++; give_verdict(); end
    initial begin
        {nrst_i, ext_en_i, ext_aff_i, move_start_i, move_word_i} = 0;
        {intr_req_i, code_region_i, data_region_i, wait_m_i} = 0;
        {cf, cb, ck, cl, cm, cn, count_ld_i, src_ld_i, dst_ld_i} = 0;
        repeat (5) @(posedge clk_i);
        #1 nrst_i = 1;
        repeat (300) calc();
        move(1, 16'h0000, 32'h10, 32'h90, 0);
        move(0, 16'h0300, 32'h10, 32'h90, 0);
        move(0, 16'hab05, 32'h20, 32'ha0, 0);
        for (int j = 0; j < 4; j++) move(1, 16'({$random(seed)} % 20 + 1),
            32'(j * 8), 32'(j * 8 + 128), 0);
        move(1, 16'h000c, 32'h40, 32'hc0, 5);
        move(1, word_count_reg, source_pointer_reg, dest_pointer_reg, 0);
        repeat (4) @(posedge clk_i);
        give_verdict();
    end
endmodule // block_move_and_state_timing_tb

/* test/bmst_core_asserts.sv */
module bmst_core_asserts #(parameter WAIT_W = 4) (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        move_start_i,
    input wire logic        move_word_i,
    input wire logic        intr_req_i,
    input wire logic [15:0] count_ld_i,
    input wire logic        move_busy_o,
    input wire logic        move_done_o,
    input wire logic        move_susp_o,
    input wire logic [31:0] source_pointer_reg,
    input wire logic [31:0] dest_pointer_reg,
    input wire logic [19:0] move_states_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic [31:0] mem_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Start only counts while idle
    wire go = move_start_i && !move_busy_o;
    start_busy_a: assert property (go |=> move_busy_o)
        else $error("move not started");
    zero_done_a: assert property (
        go && move_word_i && count_ld_i == 16'h0000 |-> ##2 move_done_o)
        else $error("zero move not done in 2");
    word_cost_a: assert property (
        go && move_word_i |=> move_states_o == 4 + 2 * $past(count_ld_i))
        else $error("word move cost wrong");
    byte_cost_a: assert property (go && !move_word_i |=>
        move_states_o == 4 + 2 * ($past(count_ld_i) & 16'h00ff))
        else $error("byte move cost wrong");
    copy_order_a: assert property (
        mem_rd_o |-> mem_addr_o == source_pointer_reg ##1 mem_wr_o)
        else $error("read not followed by write");
    dest_step_a: assert property (
        mem_wr_o |-> dest_pointer_reg == mem_addr_o + 32'h1)
        else $error("dest pointer not advanced");
    susp_cause_a: assert property (move_susp_o |-> $past(intr_req_i))
        else $error("suspend without request");
    susp_edge_a: assert property (mem_rd_o |=> !move_susp_o)
        else $error("suspend mid iteration");
    done_idle_a: assert property (move_done_o |-> !move_busy_o)
        else $error("busy at done");
endmodule // bmst_core_asserts

bind bmst_core bmst_core_asserts #(.WAIT_W(WAIT_W)) u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .move_start_i(move_start_i),
    .move_word_i(move_word_i), .intr_req_i(intr_req_i),
    .count_ld_i(count_ld_i), .move_busy_o(move_busy_o),
    .move_done_o(move_done_o), .move_susp_o(move_susp_o),
    .source_pointer_reg(source_pointer_reg),
    .dest_pointer_reg(dest_pointer_reg), .move_states_o(move_states_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o));

/* test/bmst_mem_model.sv */
module bmst_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,    // Read strobe
    input  wire logic        wr_i,    // Write strobe
    input  wire logic [31:0] addr_i,  // Low byte used
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];  // Byte array, known pattern
    initial begin
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
    end
    // one-state access: data stands in the strobe's own state
    // Idle bus shows the inverse so stale data never matches
    always_comb rdata_o = rd_i ? mem[addr_i[7:0]] : ~mem[addr_i[7:0]];
    // Write lands at the edge that ends the write state
    always @(posedge clk_i) begin
        if (wr_i) mem[addr_i[7:0]] <= wdata_i;
    end
endmodule // bmst_mem_model
